// *** core/sase_core.sv ***
// Halt and subtract execution core with a classic Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// [RULE1] Subtract gives file register minus accumulator, two's complement.
// [RULE2] Destination bit clear: the difference goes to the accumulator only.
// [RULE3] Destination bit set: the difference goes back to the file register.
// [RULE4] File operand: five-bit address 0..31 from the low instruction bits.
// [RULE5] A zero or positive difference sets carry, meaning no borrow.
// [RULE6] Negative difference clears carry and keeps the wrapped 8-bit value.
// [RULE7] Halt clears watchdog, assigned prescaler, power-down; sets timeout.
// [RULE8] After halt the oscillator and fetch stop until a wake-up event.
module sase_core (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    // Wake-up pin and power state
    input  wire logic        wake_pin,
    output var  logic        osc_run,
    output var  logic        fetch_en
);
    ////////////////////////////////////////////////////////////////////
    // Declarations
    sase_pkg::sase_state_t state;
    sase_pkg::sase_state_t next_state;

    logic [7:0]  acc;
    logic [7:0]  file_mem [sase_pkg::nfile];
    logic [4:0]  status;
    logic        psa;
    logic [7:0]  wdog;
    logic [7:0]  pre;
    logic        wake_meta;
    logic        wake_sync;

    logic        req;
    logic        wr_now;
    logic        lane0;
    logic [11:0] instr;
    logic        exec;
    logic        do_sub;
    logic        do_halt;
    logic [4:0]  faddr;
    logic        to_file;
    logic        wake_req;
    logic [31:0] next_rdata;
    logic [7:0]  pre_tick;

    sase_alu_if alu_bus ();

    sase_alu u_alu (
        .bus (alu_bus.alu)
    );

    ////////////////////////////////////////////////////////////////////
    // Address decode helpers
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] r);
        hit = (a == r);
    endfunction

    function automatic logic in_file(input logic [7:0] a);
        in_file = (a >= sase_pkg::reg_file_lo) &&
                  (a <= sase_pkg::reg_file_hi) && (a[1:0] == 2'b00);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Bus handshake
    assign req    = wb_cyc_i && wb_stb_i;
    // Writes land on the edge where ack is seen high
    assign wr_now = req && wb_we_i && wb_ack_o;
    assign lane0  = wb_sel_i[0];

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Instruction issue
    always_comb begin
        instr = wb_dat_i[sase_pkg::instr_w-1:0];
    end

    // Instruction writes are dropped while halted
    assign exec    = wr_now && lane0 && wb_sel_i[1] &&
                     hit(wb_adr_i, sase_pkg::reg_instr) &&
                     (state == sase_pkg::sase_run);          // [RULE8]
    assign do_sub  = exec &&
                     (instr[sase_pkg::op_hi:sase_pkg::op_lo] ==
                      sase_pkg::op_sub);
    assign do_halt = exec && (instr == sase_pkg::op_halt);
    assign faddr   = instr[sase_pkg::faddr_w-1:0];           // [RULE4]
    assign to_file = instr[sase_pkg::dest_bit];

    // File register minus accumulator [RULE1]
    assign alu_bus.minuend    = file_mem[faddr]; // [RULE1]
    assign alu_bus.subtrahend = acc;

    ////////////////////////////////////////////////////////////////////
    // Wake-up synchroniser
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else begin
            wake_meta <= wake_pin;
            wake_sync <= wake_meta;
        end
    end

    assign wake_req = wake_sync ||
                      (wr_now && lane0 &&
                       hit(wb_adr_i, sase_pkg::reg_ctrl) &&
                       wb_dat_i[sase_pkg::ctl_wake]);

    ////////////////////////////////////////////////////////////////////
    // Power state
    always_comb begin
        next_state = state;
        case (state)
            sase_pkg::sase_run: begin
                if (do_halt) begin
                    next_state = sase_pkg::sase_halt;        // [RULE8]
                end
            end
            sase_pkg::sase_halt: begin
                if (wake_req) begin
                    next_state = sase_pkg::sase_run;
                end
            end
            default: begin
                next_state = sase_pkg::sase_run;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state    <= sase_pkg::sase_run;
            osc_run  <= 1'b1;
            fetch_en <= 1'b1;
        end else begin
            state    <= next_state;
            // Oscillator and fetch stop right after halt [RULE8]
            osc_run  <= (next_state == sase_pkg::sase_run);
            fetch_en <= (next_state == sase_pkg::sase_run);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Accumulator
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acc <= sase_pkg::acc_rst;
        end else if (do_sub && !to_file) begin
            acc <= alu_bus.diff;                             // [RULE2]
        end else if (wr_now && lane0 &&
                     hit(wb_adr_i, sase_pkg::reg_acc)) begin
            acc <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // File registers
    // Difference write-back outranks a bus write in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < sase_pkg::nfile; gi++) begin : g_file
            localparam logic [4:0] idx = 5'(gi);
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    file_mem[gi] <= sase_pkg::file_rst;
                end else if (do_sub && to_file && faddr == idx) begin
                    file_mem[gi] <= alu_bus.diff;            // [RULE3]
                end else if (wr_now && lane0 && in_file(wb_adr_i) &&
                             wb_adr_i[6:2] == idx) begin
                    file_mem[gi] <= wb_dat_i[7:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Status flags
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            status <= sase_pkg::status_rst;
        end else if (do_sub) begin
            status[sase_pkg::st_carry]  <= alu_bus.carry;    // [RULE5] [RULE6]
            status[sase_pkg::st_hcarry] <= alu_bus.hcarry;
            status[sase_pkg::st_zero]   <= alu_bus.zero;
        end else if (do_halt) begin
            status[sase_pkg::st_timeout] <= 1'b1;            // [RULE7]
            status[sase_pkg::st_pdown]   <= 1'b0;            // [RULE7]
        end else if (wr_now && lane0 &&
                     hit(wb_adr_i, sase_pkg::reg_status)) begin
            // Power flags are hardware-owned; only ALU flags are writable
            status[sase_pkg::st_carry]  <= wb_dat_i[sase_pkg::st_carry];
            status[sase_pkg::st_hcarry] <= wb_dat_i[sase_pkg::st_hcarry];
            status[sase_pkg::st_zero]   <= wb_dat_i[sase_pkg::st_zero];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            psa <= sase_pkg::psa_rst;
        end else if (wr_now && lane0 &&
                     hit(wb_adr_i, sase_pkg::reg_ctrl)) begin
            psa <= wb_dat_i[sase_pkg::ctl_psa];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Watchdog and prescaler
    // Keeps counting while halted; it runs from clock, which osc_run does not gate
    assign pre_tick = pre + 8'h01;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pre <= sase_pkg::pre_clr;
        end else if (do_halt && psa) begin
            pre <= sase_pkg::pre_clr;                        // [RULE7]
        end else if (psa) begin
            pre <= pre_tick;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wdog <= sase_pkg::wdog_clr;
        end else if (do_halt) begin
            wdog <= sase_pkg::wdog_clr;                      // [RULE7]
        end else if (!psa || pre_tick == sase_pkg::pre_clr) begin
            wdog <= wdog + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit(wb_adr_i, sase_pkg::reg_acc)) begin
            next_rdata[7:0] = acc;
        end else if (hit(wb_adr_i, sase_pkg::reg_status)) begin
            next_rdata[sase_pkg::status_w-1:0] = status;
        end else if (hit(wb_adr_i, sase_pkg::reg_ctrl)) begin
            next_rdata[sase_pkg::ctl_psa] = psa;
        end else if (hit(wb_adr_i, sase_pkg::reg_wdog)) begin
            next_rdata[7:0] = wdog;
            next_rdata[sase_pkg::wd_pre_lsb +: 8] = pre;
        end else if (in_file(wb_adr_i)) begin
            next_rdata[7:0] = file_mem[wb_adr_i[6:2]];
        end
    end

    // Unmapped and write-only addresses read as zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i && !wb_ack_o) begin
            wb_dat_o <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// *** core/sase_pkg.sv ***
// Package: register map, field layout and opcodes of the execute block
`default_nettype none
package sase_pkg;
    // Register byte addresses
    localparam logic [7:0] reg_instr    = 8'h00;
    localparam logic [7:0] reg_acc      = 8'h04;
    localparam logic [7:0] reg_status   = 8'h08;
    localparam logic [7:0] reg_ctrl     = 8'h0c;
    localparam logic [7:0] reg_wdog     = 8'h10;
    localparam logic [7:0] reg_file_lo  = 8'h80;
    localparam logic [7:0] reg_file_hi  = 8'hfc;

    // Widths
    localparam int data_w  = 8;
    localparam int instr_w = 12;
    localparam int faddr_w = 5;
    localparam int nfile   = 32;

    // Status fields
    localparam int st_carry   = 0;
    localparam int st_hcarry  = 1;
    localparam int st_zero    = 2;
    localparam int st_pdown   = 3;
    localparam int st_timeout = 4;
    localparam int status_w   = 5;

    // Control fields
    localparam int ctl_psa  = 0;
    localparam int ctl_wake = 1;

    // Watchdog read layout
    localparam int wd_pre_lsb = 8;

    // Instruction fields and encodings
    localparam int          op_hi      = 11;
    localparam int          op_lo      = 6;
    localparam int          dest_bit   = 5;
    localparam logic [5:0]  op_sub     = 6'h02;
    localparam logic [11:0] op_halt    = 12'h003;

    // Reset values
    localparam logic [7:0]  acc_rst    = 8'h00;
    localparam logic [7:0]  file_rst   = 8'h00;
    localparam logic [7:0]  wdog_clr   = 8'h00;
    localparam logic [7:0]  pre_clr    = 8'h00;
    localparam logic [4:0]  status_rst = 5'h18;
    localparam logic        psa_rst    = 1'b1;

    typedef enum logic {sase_run, sase_halt} sase_state_t;
endpackage
`default_nettype wire

// *** core/sase_alu_if.sv ***
// Interface: operands and results between the core and its subtractor
`timescale 1ns/1ps
`default_nettype none
interface sase_alu_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic [7:0] diff;
    logic       carry;
    logic       hcarry;
    logic       zero;

    modport core (output minuend, output subtrahend,
                  input diff, input carry, input hcarry, input zero);
    modport alu  (input minuend, input subtrahend,
                  output diff, output carry, output hcarry, output zero);
endinterface
`default_nettype wire

// *** core/sase_alu.sv ***
// Two's complement subtractor with borrow-style flags
`timescale 1ns/1ps
`default_nettype none
module sase_alu (
    // Operands and results
    sase_alu_if.alu bus
);
    logic [8:0] wide;
    logic [4:0] low;

    // Minuend minus subtrahend as wrapped eight-bit result [RULE1] [RULE6]
    always_comb begin
        wide = {1'b0, bus.minuend} - {1'b0, bus.subtrahend};
        low  = {1'b0, bus.minuend[3:0]} - {1'b0, bus.subtrahend[3:0]};
    end

    assign bus.diff   = wide[7:0]; // [RULE1] [RULE6]
    // Carry is the inverse of borrow [RULE5] [RULE6]
    assign bus.carry  = ~wide[8]; // [RULE5] [RULE6]
    assign bus.hcarry = ~low[4];
    assign bus.zero   = (wide[7:0] == 8'h00);
endmodule
`default_nettype wire

// *** sim/sase_core_checker.sv ***
// Checker: port-level assertions for the halt and subtract core
`timescale 1ns/1ps
`default_nettype none
module sase_core_checker (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // Power
    input  wire logic        wake_pin,
    input  wire logic        osc_run,
    input  wire logic        fetch_en
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic rd;
    logic halt_wr;
    logic wake_wr;
    assign rd = wb_ack_o & !wb_we_i;
    assign halt_wr = wb_ack_o & wb_we_i & (&wb_sel_i[1:0]) & osc_run
        & (wb_adr_i == sase_pkg::reg_instr)
        & (wb_dat_i[11:0] == sase_pkg::op_halt);
    assign wake_wr = wb_ack_o & wb_we_i & wb_dat_i[1]
        & (wb_adr_i == sase_pkg::reg_ctrl);
    ////////////////////////////////////////////////////////////////////////
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without request");
    a_instr_zero: assert property (rd && wb_adr_i == sase_pkg::reg_instr
        |-> wb_dat_o == 32'h0) else $error("instruction read not zero");
    a_halt_stops: assert property (
        halt_wr |-> ##[1:2] !osc_run) else $error("oscillator still runs");
    a_fetch_osc: assert property (fetch_en == osc_run)
        else $error("fetch and oscillator differ");
    a_halt_holds: assert property (
        !osc_run && !wake_pin && !$past(wake_pin) && !$past(wake_pin, 2)
        && !$past(wake_pin, 3) && !wake_wr && !$past(wake_wr)
        |=> !osc_run) else $error("woke without cause");
    a_halt_flags: assert property (
        rd && !osc_run && wb_adr_i == sase_pkg::reg_status
        |-> wb_dat_o[4:3] == 2'b10) else $error("power flags wrong");
endmodule
bind sase_core sase_core_checker u_chk (.clock(clock), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wake_pin(wake_pin),
    .osc_run(osc_run), .fetch_en(fetch_en));
`default_nettype wire

// *** sim/sase_core_bench.sv ***
// Testbench: subtract and halt scenarios over the register bus
`timescale 1ns/1ps
`default_nettype none
module sase_core_bench;
    logic        clock;
    logic        sys_rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic        wake_pin;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        osc_run;
    logic        fetch_en;
    logic [31:0] q;
    int          mismatches;
    int          checks_done;
    int          seed;
    int          i;
    int          f;
    int          d;
    int          a;
    int          v;
    int          r;
    sase_core u_dut (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wake_pin(wake_pin), .osc_run(osc_run), .fetch_en(fetch_en));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Holds the request until ack is sampled, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] ad,
                       input logic [31:0] dt);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= ad;
        wdat <= dt;
        n = 0;
        @(posedge clock);
        while (ack !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        if (n == 40) begin
            mismatches++;
            $display("unexpected at %0t: no ack", $time);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        {cyc, stb, we, wake_pin} = 4'h0;
        sel = 4'h0;
        adr = 8'h00;
        wdat = 32'h0;
        seed = 61947;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        bus(1'b0, sase_pkg::reg_status, 32'h0);
        cmp(q, 32'h18);
        // Power flags are hardware-owned, ALU flags writable
        bus(1'b1, sase_pkg::reg_status, 32'h07);
        bus(1'b0, sase_pkg::reg_status, 32'h0);
        cmp(q, 32'h1f);
        bus(1'b0, 8'h40, 32'h0);
        cmp(q, 32'h0);
        for (i = 0; i < 40; i++) begin
            a = $random(seed) & 255;
            v = $random(seed) & 255;
            f = $random(seed) & 31;
            d = $random(seed) & 1;
            if (i < 3) begin
                v = 3 - i;
                a = 2;
            end
            if (i == 3)
                f = 31;
            bus(1'b1, sase_pkg::reg_acc, 32'(a));
            bus(1'b1, sase_pkg::reg_file_lo + 8'(4 * f), 32'(v));
            bus(1'b1, sase_pkg::reg_instr,
                {20'h0, sase_pkg::op_sub, 1'(d), 5'(f)});
            r = (v - a) & 255;
            bus(1'b0, sase_pkg::reg_acc, 32'h0);
            cmp(q, 32'(d ? a : r));
            bus(1'b0, sase_pkg::reg_file_lo + 8'(4 * f), 32'h0);
            cmp(q, 32'(d ? r : v));
            bus(1'b0, sase_pkg::reg_status, 32'h0);
            cmp(q, {27'h0, 2'b11, r == 0, (v & 15) >= (a & 15),
                    v >= a});
        end
        bus(1'b0, sase_pkg::reg_instr, 32'h0);
        cmp(q, 32'h0);
        // Second pass wakes by pin, first by the control write
        for (i = 0; i < 2; i++) begin
            bus(1'b1, sase_pkg::reg_ctrl, 32'(1 - i));
            bus(1'b0, sase_pkg::reg_ctrl, 32'h0);
            cmp(q, 32'(1 - i));
            bus(1'b1, sase_pkg::reg_acc, 32'h5a);
            bus(1'b1, sase_pkg::reg_file_lo, 32'h0);
            bus(1'b1, sase_pkg::reg_instr, 32'(sase_pkg::op_halt));
            bus(1'b0, sase_pkg::reg_wdog, 32'h0);
            v = i ? q[7:0] < 8 : q[7:0] == 0 && q[15:8] < 8;
            cmp(32'(v), 32'h1);
            cmp({30'h0, osc_run, fetch_en}, 32'h0);
            bus(1'b0, sase_pkg::reg_status, 32'h0);
            cmp(32'(q[4:3]), 32'h2);
            // A subtract issued while halted must leave the accumulator
            bus(1'b1, sase_pkg::reg_instr, {20'h0, sase_pkg::op_sub, 6'h00});
            bus(1'b0, sase_pkg::reg_acc, 32'h0);
            cmp(q, 32'h5a);
            if (i == 0)
                bus(1'b1, sase_pkg::reg_ctrl, 32'h3);
            else
                wake_pin <= 1'b1;
            for (a = 0; a < 10 && osc_run !== 1'b1; a++)
                @(posedge clock);
            wake_pin <= 1'b0;
            cmp(32'(osc_run), 32'h1);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
